// ==== dssq_top.sv ====
// data set 2 registers and step-change sequencer behind an AXI4-Lite slave
// assumes one 40 MHz clock; the two discrete inputs are asynchronous pins
`timescale 1ns/1ps

// Function
// R1 - coarse target: signed units of 10000 pulses, -9999..+9999, default 0
// R2 - fine target: signed single pulses -9999..+9999, added to coarse part
// R3 - type 0 empty, 1 absolute target, 2 relative target
// R4 - condition types none, delay, edge, level; one watches step, two secondary
// R5 - logic field: 0 no combination, 1 both conditions, 2 either condition
// R6 - condition one value: 16-bit unsigned, default 0
// R7 - condition two value: 16-bit unsigned, default 0
// R8 - no-condition type ignores its value and is met at once
// R9 - delay type waits value milliseconds before being met
// R10 - edge type: value 0 rising, 1 falling, 2 either edge
// R11 - level type: value 3 input high, value 4 input low
// R12 - attribute resets to all zero fields
// R13 - inputs synchronised first; with no combination only condition one counts
module dssq_top #(
	parameter int MS_CYCLES = dssq_pkg::MS_CYCLES
) (
	// clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RST_N,
	input  wire logic        CE,
	// discrete inputs
	input  wire logic        STEP_IN,
	input  wire logic        SECONDARY_CONDITION_INPUT,
	// sequencer outputs
	output logic             STEP_ADVANCE,
	output logic             SEQ_BUSY,
	output logic             TARGET_RELATIVE,
	output logic [31:0]      TARGET_POS,
	// axi4-lite write address
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	// axi4-lite write data
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	// axi4-lite write response
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	// axi4-lite read address
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	// axi4-lite read data
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY
);
	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	dssq_pkg::dssq_cfg_s   cfg_r;
	dssq_pkg::dssq_state_e state_r;
	logic [1:0]  sync1_r;
	logic [1:0]  sync2_r;
	logic        awready_r;
	logic        wready_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        arready_r;
	logic        rvalid_r;
	logic [1:0]  rresp_r;
	logic [31:0] rdata_r;
	logic [7:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        aw_full_r;
	logic        w_full_r;
	logic        wr_fire;
	logic [15:0] wr_val;
	logic        wr_ok;
	logic        wr_map;
	logic        start_r;
	logic        abort_r;
	logic        arm;
	logic        done_r;
	logic        empty_r;
	logic        step_r;
	logic        busy_r;
	logic [31:0] target_r;
	logic        rel_r;
	logic [15:0] presc_r;
	logic        ms_tick;
	logic        c1_met;
	logic        c2_met;
	logic        comb_met;
	logic        clr_done;
	logic        clr_empty;
	logic [31:0] rd_mux;
	logic        rd_map;
	logic signed [31:0] target_calc;

	localparam logic [15:0] PRESC_LAST = 16'(MS_CYCLES - 1);

	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync1_r <= 2'h0;
			sync2_r <= 2'h0;
		end else if (CE) begin
			sync1_r <= {SECONDARY_CONDITION_INPUT, STEP_IN}; // R13
			sync2_r <= sync1_r; // R13
		end
	end

	// ---------------------------------------------------------------
	// axi4-lite write path
	// ---------------------------------------------------------------
	assign wr_fire = aw_full_r && w_full_r && !bvalid_r;
	// merge byte lanes 0 and 1 into the old word
	always_comb begin
		wr_val = 16'h0000;
		case (awaddr_r)
			dssq_pkg::OFF_MOTION: wr_val = {14'h0000, cfg_r.motion};
			dssq_pkg::OFF_FINE:   wr_val = cfg_r.fine;
			dssq_pkg::OFF_COARSE: wr_val = cfg_r.coarse;
			dssq_pkg::OFF_ATTR:   wr_val = cfg_r.attr;
			dssq_pkg::OFF_VAL1:   wr_val = cfg_r.val1;
			dssq_pkg::OFF_VAL2:   wr_val = cfg_r.val2;
			default:              wr_val = 16'h0000;
		endcase
		if (wstrb_r[0]) begin
			wr_val[7:0] = wdata_r[7:0];
		end
		if (wstrb_r[1]) begin
			wr_val[15:8] = wdata_r[15:8];
		end
	end

	// out-of-range targets and motion types are refused with slverr
	always_comb begin
		wr_map = 1'b1;
		wr_ok  = 1'b1;
		case (awaddr_r)
			dssq_pkg::OFF_MOTION: wr_ok = wr_val <= {14'h0000, dssq_pkg::MOTION_MAX}; // R3
			dssq_pkg::OFF_FINE, dssq_pkg::OFF_COARSE: begin
				wr_ok = $signed(wr_val) <= dssq_pkg::TGT_MAX
				     && $signed(wr_val) >= dssq_pkg::TGT_MIN; // R1 R2
			end
			dssq_pkg::OFF_ATTR, dssq_pkg::OFF_VAL1, dssq_pkg::OFF_VAL2,
			dssq_pkg::OFF_CTRL, dssq_pkg::OFF_STATUS: wr_ok = 1'b1;
			default: begin
				wr_map = 1'b0;
				wr_ok  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			awaddr_r  <= 8'h00;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= dssq_pkg::RESP_OKAY;
		end else if (CE) begin
			if (S_AXI_AWVALID && awready_r) begin
				aw_full_r <= 1'b1;
				awready_r <= 1'b0;
				awaddr_r  <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && wready_r) begin
				w_full_r <= 1'b1;
				wready_r <= 1'b0;
				wdata_r  <= S_AXI_WDATA;
				wstrb_r  <= S_AXI_WSTRB;
			end
			if (wr_fire) begin
				aw_full_r <= 1'b0;
				w_full_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
				bvalid_r  <= 1'b1;
				bresp_r   <= (wr_ok && wr_map) ? dssq_pkg::RESP_OKAY : dssq_pkg::RESP_SLVERR;
			end else if (bvalid_r && S_AXI_BREADY) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// data set 2 parameters
	// ---------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cfg_r <= '0; // R1 R2 R6 R7 R12
		end else if (CE && wr_fire && wr_ok) begin
			case (awaddr_r)
				dssq_pkg::OFF_MOTION: cfg_r.motion <= wr_val[1:0]; // R3
				dssq_pkg::OFF_FINE:   cfg_r.fine   <= wr_val; // R2
				dssq_pkg::OFF_COARSE: cfg_r.coarse <= wr_val; // R1
				dssq_pkg::OFF_ATTR:   cfg_r.attr   <= wr_val; // R4 R5
				dssq_pkg::OFF_VAL1:   cfg_r.val1   <= wr_val; // R6
				dssq_pkg::OFF_VAL2:   cfg_r.val2   <= wr_val; // R7
				default:              cfg_r        <= cfg_r;
			endcase
		end
	end

	// control pulses and write-one-to-clear requests
	assign clr_done  = wr_fire && awaddr_r == dssq_pkg::OFF_STATUS && wstrb_r[0]
	                   && wdata_r[dssq_pkg::STAT_DONE];
	assign clr_empty = wr_fire && awaddr_r == dssq_pkg::OFF_STATUS && wstrb_r[0]
	                   && wdata_r[dssq_pkg::STAT_EMPTY];

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			start_r <= 1'b0;
			abort_r <= 1'b0;
		end else if (CE) begin
			start_r <= wr_fire && awaddr_r == dssq_pkg::OFF_CTRL && wstrb_r[0]
			           && wdata_r[dssq_pkg::CTRL_START];
			abort_r <= wr_fire && awaddr_r == dssq_pkg::OFF_CTRL && wstrb_r[0]
			           && wdata_r[dssq_pkg::CTRL_ABORT];
		end
	end

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	// an empty set is never armed, so no step is produced for it
	assign arm = start_r && state_r == dssq_pkg::SQ_IDLE
	             && cfg_r.motion != dssq_pkg::MOT_EMPTY; // R3
	assign target_calc = 32'(cfg_r.coarse) * dssq_pkg::COARSE_UNIT
	                     + 32'(cfg_r.fine); // R1 R2

	// millisecond prescaler restarts on arm so delays start cleanly
	assign ms_tick = presc_r == PRESC_LAST;
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			presc_r <= 16'h0000;
		end else if (CE) begin
			if (arm || ms_tick) begin
				presc_r <= 16'h0000;
			end else begin
				presc_r <= presc_r + 16'h0001;
			end
		end
	end

	dssq_cond u_cond_one (
		.clk     (REF_CLK),
		.rst_n   (RST_N),
		.ce      (CE),
		.arm     (arm),
		.active  (state_r == dssq_pkg::SQ_WAIT),
		.ms_tick (ms_tick),
		.typ     (cfg_r.attr[dssq_pkg::ATTR_C1_LSB +: 4]), // R4
		.val     (cfg_r.val1), // R6
		.sig     (sync2_r[0]), // R4
		.met     (c1_met)
	);

	dssq_cond u_cond_two (
		.clk     (REF_CLK),
		.rst_n   (RST_N),
		.ce      (CE),
		.arm     (arm),
		.active  (state_r == dssq_pkg::SQ_WAIT),
		.ms_tick (ms_tick),
		.typ     (cfg_r.attr[dssq_pkg::ATTR_C2_LSB +: 4]), // R4
		.val     (cfg_r.val2), // R7
		.sig     (sync2_r[1]), // R4
		.met     (c2_met)
	);

	always_comb begin
		case (cfg_r.attr[dssq_pkg::ATTR_LOG_LSB +: 4])
			dssq_pkg::LG_AND: comb_met = c1_met & c2_met; // R5
			dssq_pkg::LG_OR:  comb_met = c1_met | c2_met; // R5
			default:          comb_met = c1_met; // R13
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_r  <= dssq_pkg::SQ_IDLE;
			busy_r   <= 1'b0;
			step_r   <= 1'b0;
			target_r <= 32'h0000_0000;
			rel_r    <= 1'b0;
		end else if (CE) begin
			step_r <= 1'b0;
			case (state_r)
				dssq_pkg::SQ_IDLE: begin
					if (arm) begin
						state_r  <= dssq_pkg::SQ_WAIT;
						busy_r   <= 1'b1;
						target_r <= target_calc; // R1 R2
						rel_r    <= cfg_r.motion == dssq_pkg::MOT_REL; // R3
					end
				end
				dssq_pkg::SQ_WAIT: begin
					if (abort_r) begin
						state_r <= dssq_pkg::SQ_IDLE;
						busy_r  <= 1'b0;
					end else if (comb_met) begin
						state_r <= dssq_pkg::SQ_IDLE;
						busy_r  <= 1'b0;
						step_r  <= 1'b1; // R5
					end
				end
				default: begin
					state_r <= dssq_pkg::SQ_IDLE;
					busy_r  <= 1'b0;
				end
			endcase
		end
	end

	// sticky flags: a new event beats a clear in the same cycle
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			done_r  <= 1'b0;
			empty_r <= 1'b0;
		end else if (CE) begin
			if (step_r) begin
				done_r <= 1'b1;
			end else if (clr_done) begin
				done_r <= 1'b0;
			end
			if (start_r && cfg_r.motion == dssq_pkg::MOT_EMPTY) begin
				empty_r <= 1'b1;
			end else if (clr_empty) begin
				empty_r <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// axi4-lite read path
	// ---------------------------------------------------------------
	always_comb begin
		rd_map = 1'b1;
		case (S_AXI_ARADDR)
			dssq_pkg::OFF_MOTION: rd_mux = {30'h0000_0000, cfg_r.motion};
			dssq_pkg::OFF_FINE:   rd_mux = {16'h0000, cfg_r.fine};
			dssq_pkg::OFF_COARSE: rd_mux = {16'h0000, cfg_r.coarse};
			dssq_pkg::OFF_ATTR:   rd_mux = {16'h0000, cfg_r.attr};
			dssq_pkg::OFF_VAL1:   rd_mux = {16'h0000, cfg_r.val1};
			dssq_pkg::OFF_VAL2:   rd_mux = {16'h0000, cfg_r.val2};
			dssq_pkg::OFF_CTRL:   rd_mux = 32'h0000_0000;
			dssq_pkg::OFF_STATUS: rd_mux = {28'h000_0000, rel_r, empty_r, done_r,
			                                state_r == dssq_pkg::SQ_WAIT};
			dssq_pkg::OFF_TARGET: rd_mux = target_r;
			default: begin
				rd_mux = 32'h0000_0000;
				rd_map = 1'b0;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= dssq_pkg::RESP_OKAY;
		end else if (CE) begin
			if (S_AXI_ARVALID && arready_r) begin
				arready_r <= 1'b0;
				rvalid_r  <= 1'b1;
				rdata_r   <= rd_mux;
				rresp_r   <= rd_map ? dssq_pkg::RESP_OKAY : dssq_pkg::RESP_SLVERR;
			end else if (rvalid_r && S_AXI_RREADY) begin
				rvalid_r  <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	assign S_AXI_AWREADY   = awready_r;
	assign S_AXI_WREADY    = wready_r;
	assign S_AXI_BVALID    = bvalid_r;
	assign S_AXI_BRESP     = bresp_r;
	assign S_AXI_ARREADY   = arready_r;
	assign S_AXI_RVALID    = rvalid_r;
	assign S_AXI_RDATA     = rdata_r;
	assign S_AXI_RRESP     = rresp_r;
	assign STEP_ADVANCE    = step_r;
	assign SEQ_BUSY        = busy_r;
	assign TARGET_RELATIVE = rel_r;
	assign TARGET_POS      = target_r;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	step_cause_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R5
		$rose(step_r) |-> $past(comb_met && state_r == dssq_pkg::SQ_WAIT && !abort_r))
		else $error("step without combined condition");
	and_both_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R5
		$rose(step_r) && $past(cfg_r.attr[dssq_pkg::ATTR_LOG_LSB +: 4]) == dssq_pkg::LG_AND
		|-> $past(c1_met && c2_met))
		else $error("and combination stepped on one condition");
	empty_arm_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R3
		CE && start_r && cfg_r.motion == dssq_pkg::MOT_EMPTY && state_r == dssq_pkg::SQ_IDLE
		|=> state_r == dssq_pkg::SQ_IDLE && empty_r)
		else $error("empty data set was armed");
	target_calc_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R1 R2
		CE && arm |=> $signed(target_r) == $past(32'(cfg_r.coarse)) * dssq_pkg::COARSE_UNIT
		+ $past(32'(cfg_r.fine)))
		else $error("target not coarse times 10000 plus fine");
	range_err_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R1
		CE && wr_fire && awaddr_r == dssq_pkg::OFF_COARSE
		&& $signed(wr_val) > dssq_pkg::TGT_MAX
		|=> bvalid_r && bresp_r == dssq_pkg::RESP_SLVERR && $stable(cfg_r.coarse))
		else $error("out of range coarse target accepted");
	sync_path_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R13
		CE ##1 CE |-> sync2_r[0] == $past(STEP_IN, 2))
		else $error("step input not delayed by two stages");

	step_and_c: cover property (@(posedge REF_CLK) disable iff (!RST_N)
		$rose(step_r) && cfg_r.attr[dssq_pkg::ATTR_LOG_LSB +: 4] == dssq_pkg::LG_AND);
	step_delay_c: cover property (@(posedge REF_CLK) disable iff (!RST_N)
		$rose(step_r) && cfg_r.attr[dssq_pkg::ATTR_C1_LSB +: 4] == dssq_pkg::CT_DELAY);
	slverr_c: cover property (@(posedge REF_CLK) disable iff (!RST_N)
		bvalid_r && bresp_r == dssq_pkg::RESP_SLVERR);

endmodule : dssq_top

// ==== dssq_pkg.sv ====
// package for the data set 2 step sequencer
// assumes a single 40 MHz clock and an AXI4-Lite register bus
package dssq_pkg;

	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_MOTION = 8'h00;
	localparam logic [7:0] OFF_FINE   = 8'h04;
	localparam logic [7:0] OFF_COARSE = 8'h08;
	localparam logic [7:0] OFF_ATTR   = 8'h0C;
	localparam logic [7:0] OFF_VAL1   = 8'h10;
	localparam logic [7:0] OFF_VAL2   = 8'h14;
	localparam logic [7:0] OFF_CTRL   = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1C;
	localparam logic [7:0] OFF_TARGET = 8'h20;

	// ---------------------------------------------------------------
	// fields and codes
	// ---------------------------------------------------------------
	localparam int ATTR_C1_LSB  = 0;
	localparam int ATTR_C2_LSB  = 4;
	localparam int ATTR_LOG_LSB = 8;
	localparam int CTRL_START   = 0;
	localparam int CTRL_ABORT   = 1;
	localparam int STAT_DONE    = 1;
	localparam int STAT_EMPTY   = 2;

	localparam logic [1:0] MOT_EMPTY = 2'h0;
	localparam logic [1:0] MOT_ABS   = 2'h1;
	localparam logic [1:0] MOT_REL   = 2'h2;

	localparam logic [3:0] CT_NONE  = 4'h0;
	localparam logic [3:0] CT_DELAY = 4'h1;
	localparam logic [3:0] CT_EDGE  = 4'h2;
	localparam logic [3:0] CT_LEVEL = 4'h3;

	localparam logic [3:0] LG_NONE = 4'h0;
	localparam logic [3:0] LG_AND  = 4'h1;
	localparam logic [3:0] LG_OR   = 4'h2;

	localparam logic [15:0] EV_RISE = 16'h0000;
	localparam logic [15:0] EV_FALL = 16'h0001;
	localparam logic [15:0] EV_HIGH = 16'h0003;
	localparam logic [15:0] EV_LOW  = 16'h0004;

	localparam logic signed [15:0] TGT_MAX     = 16'sh270F;
	localparam logic signed [15:0] TGT_MIN     = -16'sh270F;
	localparam logic signed [31:0] COARSE_UNIT = 32'sh0000_2710;
	localparam logic [1:0]         MOTION_MAX  = 2'h2;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int MS_NS         = 1000000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [1:0]         motion;
		logic signed [15:0] fine;
		logic signed [15:0] coarse;
		logic [15:0]        attr;
		logic [15:0]        val1;
		logic [15:0]        val2;
	} dssq_cfg_s;

	typedef enum logic [1:0] {
		SQ_IDLE = 2'b00,
		SQ_WAIT = 2'b01
	} dssq_state_e;

endpackage : dssq_pkg

// ==== dssq_cond.sv ====
// one step-change condition evaluator
// assumes sig is already synchronised and ms_tick is a one-cycle pulse
`timescale 1ns/1ps
module dssq_cond (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// control
	input  wire logic        arm,
	input  wire logic        active,
	input  wire logic        ms_tick,
	input  wire logic [3:0]  typ,
	input  wire logic [15:0] val,
	input  wire logic        sig,
	// result
	output logic             met
);
	logic        met_r;
	logic        prev_r;
	logic [15:0] cnt_r;
	logic        rise;
	logic        fall;
	logic        edge_hit;
	logic        lvl_ok;

	assign rise = sig & ~prev_r;
	assign fall = ~sig & prev_r;
	// values above 2 fall back to either edge
	assign edge_hit = (val == dssq_pkg::EV_RISE) ? rise :
	                  (val == dssq_pkg::EV_FALL) ? fall : (rise | fall); // R10
	// only value 4 asks for low, anything else for high
	assign lvl_ok = (val == dssq_pkg::EV_LOW) ? ~sig : sig; // R11
	assign met = met_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_r <= 1'b0;
		end else if (ce) begin
			prev_r <= sig;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			met_r <= 1'b0;
			cnt_r <= 16'h0000;
		end else if (ce) begin
			if (arm) begin
				met_r <= 1'b0;
				cnt_r <= val;
			end else if (active) begin
				case (typ)
					dssq_pkg::CT_NONE: begin
						met_r <= 1'b1; // R8
					end
					dssq_pkg::CT_DELAY: begin
						if (cnt_r == 16'h0000) begin
							met_r <= 1'b1; // R9
						end else if (ms_tick) begin
							cnt_r <= cnt_r - 16'h0001; // R9
						end
					end
					dssq_pkg::CT_EDGE: begin
						if (edge_hit) begin
							met_r <= 1'b1; // R10
						end
					end
					dssq_pkg::CT_LEVEL: begin
						met_r <= lvl_ok; // R11
					end
					default: begin
						met_r <= 1'b1;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	none_met_a: assert property (@(posedge clk) disable iff (!rst_n) // R8
		ce && active && !arm && typ == dssq_pkg::CT_NONE |=> met_r)
		else $error("no-condition type did not report met");
	edge_rise_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
		ce && active && !arm && typ == dssq_pkg::CT_EDGE && val == dssq_pkg::EV_RISE
		&& !met_r && !rise |=> !met_r)
		else $error("edge condition met without a rising edge");
	level_low_a: assert property (@(posedge clk) disable iff (!rst_n) // R11
		ce && active && !arm && typ == dssq_pkg::CT_LEVEL && val == dssq_pkg::EV_LOW
		|=> met_r == !$past(sig))
		else $error("low level condition wrong");
	delay_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
		ce && active && !arm && typ == dssq_pkg::CT_DELAY && cnt_r != 16'h0000 && !met_r
		|=> !met_r)
		else $error("delay condition met before count expired");

endmodule : dssq_cond

// ==== dssq_host.sv ====
// host pin model: drives the step and secondary discrete inputs
// assumes the bench requests levels right after a rising clock edge
`timescale 1ns/1ps
module dssq_host (
	// clock
	input  wire logic clk,
	// requested levels
	input  wire logic step_req,
	input  wire logic sec_req,
	// discrete pins
	output logic      step_pin,
	output logic      sec_pin
);
	// ---------------------------------------------------------------
	// pin drivers
	// ---------------------------------------------------------------
	// pins are always driven, so there is no released state to model
	initial begin
		step_pin = 1'b0;
		sec_pin  = 1'b0;
	end
	always @(posedge clk) begin
		step_pin <= step_req;
		sec_pin  <= sec_req;
	end
endmodule : dssq_host

// ==== dssq_top_test.sv ====
// self-checking bench for the data set 2 step sequencer
// assumes dssq_top, its AXI4-Lite slave and the dssq_host pin model
`timescale 1ns/1ps
module dssq_top_test;
	logic        clk     = 1'b0;
	logic        rst_n   = 1'b0;
	logic        step_q  = 1'b0;
	logic        sec_q   = 1'b0;
	logic [7:0]  awaddr  = 8'h00;
	logic [7:0]  araddr  = 8'h00;
	logic [31:0] wdata   = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	logic        step_p, sec_p, adv, busy, rel, awready, wready, bvalid, arready, rvalid;
	logic [31:0] tpos, rdata, d;
	logic [1:0]  bresp, rresp, r;
	int          fail_count = 0;
	int          samples_checked = 0;
	int          adv_n = 0;
	int          n0;

	always #12.5 clk = ~clk;
	always @(posedge clk) if (adv === 1'b1) adv_n <= adv_n + 1;

	dssq_host host (.clk(clk), .step_req(step_q), .sec_req(sec_q), .step_pin(step_p),
		.sec_pin(sec_p));
	// short millisecond so delay conditions finish in a few cycles
	dssq_top #(.MS_CYCLES(4)) dut (.REF_CLK(clk), .RST_N(rst_n), .CE(1'b1),
		.STEP_IN(step_p), .SECONDARY_CONDITION_INPUT(sec_p), .STEP_ADVANCE(adv),
		.SEQ_BUSY(busy), .TARGET_RELATIVE(rel), .TARGET_POS(tpos),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task test_done;
		if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		int n;
		@(posedge clk);
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		resp = bresp;
		bready <= 1'b0;
		if (n == 40) fail_count++;
		if (n == 40) test_done;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		int n;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
		if (n == 40) fail_count++;
		if (n == 40) test_done;
	endtask : rd

	// one sequencer run: step pin si, then sa after pre cycles; sc on secondary
	task automatic cond(input logic [15:0] at, v1, v2, input logic si, sa, sc,
		input int pre, met);
		int early;
		step_q <= si;
		sec_q  <= sc;
		wr(dssq_pkg::OFF_ATTR, {16'h0, at}, r);
		wr(dssq_pkg::OFF_VAL1, {16'h0, v1}, r);
		wr(dssq_pkg::OFF_VAL2, {16'h0, v2}, r);
		n0 = adv_n;
		wr(dssq_pkg::OFF_CTRL, 32'h1, r);
		repeat (pre) @(posedge clk);
		early = adv_n - n0;
		step_q <= sa;
		repeat (24) @(posedge clk);
		if (pre > 0) chk("early advance", early, 32'h0);
		chk("advance count", adv_n - n0, met);
		// abort leaves an unmet run idle again
		wr(dssq_pkg::OFF_CTRL, 32'h2, r);
		repeat (2) @(posedge clk);
		chk("busy after run", {31'h0, busy}, 32'h0);
	endtask : cond

	task automatic tgt(input logic [1:0] m, input int c, f);
		wr(dssq_pkg::OFF_MOTION, {30'h0, m}, r);
		wr(dssq_pkg::OFF_COARSE, 32'(c), r);
		wr(dssq_pkg::OFF_FINE, 32'(f), r);
		wr(dssq_pkg::OFF_ATTR, 32'h0, r);
		wr(dssq_pkg::OFF_CTRL, 32'h1, r);
		repeat (4) @(posedge clk);
		chk("target", tpos, 32'(c * 10000 + f));
		chk("relative", {31'h0, rel}, {31'h0, m == 2'h2});
		rd(dssq_pkg::OFF_TARGET, d, r);
		chk("target register", d, 32'(c * 10000 + f));
	endtask : tgt

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd(8'(4 * i), d, r);
			chk("reset value", d, 32'h0);
		end
		rd(8'h40, d, r);
		chk("unmapped", {30'h0, r}, {30'h0, dssq_pkg::RESP_SLVERR});
		wr(dssq_pkg::OFF_VAL1, 32'h0000FFFF, r);
		rd(dssq_pkg::OFF_VAL1, d, r);
		chk("value one", d, 32'h0000FFFF);
		wr(dssq_pkg::OFF_VAL2, 32'h00008001, r);
		rd(dssq_pkg::OFF_VAL2, d, r);
		chk("value two", d, 32'h00008001);
		wr(dssq_pkg::OFF_COARSE, 32'h00002710, r);
		chk("coarse range", {30'h0, r}, {30'h0, dssq_pkg::RESP_SLVERR});
		wr(dssq_pkg::OFF_FINE, 32'hFFFFD8F0, r);
		chk("fine range", {30'h0, r}, {30'h0, dssq_pkg::RESP_SLVERR});
		wr(dssq_pkg::OFF_MOTION, 32'h3, r);
		chk("type range", {30'h0, r}, {30'h0, dssq_pkg::RESP_SLVERR});
		tgt(2'h1, -3, 25);
		tgt(2'h2, 9999, -9999);
		wr(dssq_pkg::OFF_MOTION, 32'h0, r);
		wr(dssq_pkg::OFF_CTRL, 32'h1, r);
		repeat (3) @(posedge clk);
		rd(dssq_pkg::OFF_STATUS, d, r);
		chk("empty start", {31'h0, d[dssq_pkg::STAT_EMPTY]}, 32'h1);
		chk("empty busy", {31'h0, busy}, 32'h0);
		wr(dssq_pkg::OFF_MOTION, 32'h1, r);
		cond(16'h0000, 16'h0005, 16'h0, 0, 0, 0, 0, 1);
		cond(16'h0001, 16'h0003, 16'h0, 0, 0, 0, 8, 1);
		cond(16'h0002, 16'h0000, 16'h0, 0, 1, 0, 8, 1);
		cond(16'h0002, 16'h0000, 16'h0, 1, 0, 0, 8, 0);
		cond(16'h0002, 16'h0001, 16'h0, 1, 0, 0, 8, 1);
		cond(16'h0002, 16'h0002, 16'h0, 0, 1, 0, 8, 1);
		cond(16'h0002, 16'h0002, 16'h0, 1, 0, 0, 8, 1);
		cond(16'h0003, 16'h0003, 16'h0, 0, 1, 0, 8, 1);
		cond(16'h0003, 16'h0004, 16'h0, 1, 0, 0, 8, 1);
		cond(16'h0003, 16'h0003, 16'h0, 0, 0, 0, 8, 0);
		cond(16'h0133, 16'h0003, 16'h3, 1, 1, 0, 0, 0);
		cond(16'h0133, 16'h0003, 16'h3, 1, 1, 1, 0, 1);
		cond(16'h0233, 16'h0003, 16'h3, 0, 0, 1, 0, 1);
		cond(16'h0233, 16'h0003, 16'h3, 0, 0, 0, 0, 0);
		cond(16'h0033, 16'h0003, 16'h3, 0, 0, 1, 0, 0);
		cond(16'h0113, 16'h0003, 16'h2, 1, 1, 0, 4, 1);
		test_done;
	end
endmodule : dssq_top_test
